// ==== verilog/sip_regs.sv ====
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module sip_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              stop_mode,
    input  wire logic [15:0]       periph_clock_enable_1,
    input  wire logic [sip_pkg::OFFSET_W-1:0] short_offset,
    output logic [15:0]            periph_stop_clock,
    output logic [23:0]            short_eff_addr,
    output logic [17:0]            short_window_base,
    output logic [1:0]             clock_ctrl_guard,
    output logic [1:0]             mux_ctrl_guard
);
    import sip_pkg::*;

    // write channel holding registers
    logic [IDX_W-1:0] aw_idx_q;
    logic             aw_full_q;
    logic             w_full_q;
    logic [15:0]      w_data_q;
    logic [1:0]       w_strb_q;
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    // read channel
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    // register state
    logic [15:0]      stop_keep_q;
    logic [1:0]       short_hi_q;
    logic [15:0]      short_lo_q;
    logic [15:0]      stop_clk_q;
    logic [23:0]      eff_addr_q;
    logic [1:0]       clk_guard_q;
    logic [1:0]       mux_guard_q;

    // ---------------- write decode ----------------
    wire aw_take  = awvalid && awready_q;
    wire w_take   = wvalid && wready_q;
    wire do_write = aw_full_q && w_full_q && !bvalid_q;

    wire hit_keep = (aw_idx_q == IDX_STOP_KEEP_1);
    wire hit_hi   = (aw_idx_q == IDX_SHORT_HI);
    wire hit_lo   = (aw_idx_q == IDX_SHORT_LO);
    wire hit_prot = (aw_idx_q == IDX_WR_PROT);
    wire wr_hit   = hit_keep || hit_hi || hit_lo || hit_prot;

    wire [15:0] byte_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // guarded write is dropped but still answered normally
    wire clk_guard_on = clk_guard_q[GUARD_ON_BIT];
    wire wr_keep_en   = do_write && hit_keep && !clk_guard_on; // R10 R16
    wire wr_hi_en     = do_write && hit_hi && w_strb_q[0];
    wire wr_lo_en     = do_write && hit_lo;
    wire wr_prot_en   = do_write && hit_prot && w_strb_q[0];

    wire [15:0] stop_keep_d =
        ((stop_keep_q & ~byte_mask) | (w_data_q & byte_mask))
        & STOP_KEEP_MASK; // R1 R3
    wire [15:0] short_lo_d =
        (short_lo_q & ~byte_mask) | (w_data_q & byte_mask); // R7
    // only the two field bits are stored; upper bits fall away
    wire [1:0]  short_hi_d = w_data_q[1:0]; // R5 R6

    wire [1:0] clk_guard_wr = w_data_q[CLK_GUARD_LSB +: 2];
    wire [1:0] mux_guard_wr = w_data_q[MUX_GUARD_LSB +: 2];

    wire [1:0] bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
            aw_idx_q  <= '0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_idx_q  <= awaddr[IDX_W+1:2];
        end else if (bvalid_q && bready) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= wdata[15:0];
            w_strb_q <= wstrb[1:0];
        end else if (bvalid_q && bready) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= bresp_d; // R16
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ---------------- register storage ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_keep_q <= STOP_KEEP_RST; // R17
            short_hi_q  <= SHORT_HI_RST; // R8
            short_lo_q  <= SHORT_LO_RST; // R8
        end else begin
            if (wr_keep_en) begin
                stop_keep_q <= stop_keep_d;
            end
            if (wr_hi_en) begin
                short_hi_q <= short_hi_d;
            end
            if (wr_lo_en) begin
                short_lo_q <= short_lo_d;
            end
        end
    end

    sip_guard_field u_clk_guard (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_prot_en),
        .wr_val  (clk_guard_wr),
        .field_q (clk_guard_q)
    );

    sip_guard_field u_mux_guard (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_prot_en),
        .wr_val  (mux_guard_wr),
        .field_q (mux_guard_q)
    );

    // ---------------- derived outputs ----------------
    // the keep-alive only extends a clock that is already enabled
    wire [15:0] stop_clk_d = periph_clock_enable_1
        & ({16{~stop_mode}} | stop_keep_q); // R1 R2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_clk_q <= '0;
            eff_addr_q <= '0;
        end else begin
            stop_clk_q <= stop_clk_d;
            eff_addr_q <= {short_hi_q, short_lo_q, short_offset}; // R4
        end
    end

    // ---------------- read path ----------------
    wire              ar_take = arvalid && arready_q;
    wire [IDX_W-1:0]  ar_idx  = araddr[IDX_W+1:2];
    wire rd_keep = (ar_idx == IDX_STOP_KEEP_1);
    wire rd_hi   = (ar_idx == IDX_SHORT_HI);
    wire rd_lo   = (ar_idx == IDX_SHORT_LO);
    wire rd_prot = (ar_idx == IDX_WR_PROT);
    wire rd_hit  = rd_keep || rd_hi || rd_lo || rd_prot;

    wire [15:0] prot_rd = {12'h000, clk_guard_q, mux_guard_q};
    wire [15:0] rd_val  =
        rd_keep ? stop_keep_q :
        rd_hi   ? {14'h0000, short_hi_q} : // R6
        rd_lo   ? short_lo_q :
        rd_prot ? prot_rd : 16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {16'h0000, rd_val};
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    assign awready           = awready_q;
    assign wready            = wready_q;
    assign bvalid            = bvalid_q;
    assign bresp             = bresp_q;
    assign arready           = arready_q;
    assign rvalid            = rvalid_q;
    assign rdata             = rdata_q;
    assign rresp             = rresp_q;
    assign periph_stop_clock = stop_clk_q;
    assign short_eff_addr    = eff_addr_q;
    assign short_window_base = {short_hi_q, short_lo_q};
    // active bits guard the clock-enable, clock-rate, mux and test pulse fields outside
    assign clock_ctrl_guard  = clk_guard_q; // R10
    assign mux_ctrl_guard    = mux_guard_q; // R14 R15

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_taken;
        aw_full_q && w_full_q && !bvalid_q;
    endsequence

    sequence s_answer_okay;
        bvalid_q && (bresp_q == RESP_OKAY);
    endsequence

    property p_guarded_keep;
        (do_write && hit_keep && clk_guard_on) |=> $stable(stop_keep_q);
    endproperty
    a_guarded_keep: assert property (p_guarded_keep) // R10
        else $error("guarded keep-alive register changed");

    property p_guard_silent;
        (s_both_taken and (hit_keep && clk_guard_on)) |=> s_answer_okay;
    endproperty
    a_guard_silent: assert property (p_guard_silent) // R16
        else $error("guarded write not answered okay");

    property p_clk_lock;
        clk_guard_q[GUARD_LOCK_BIT] |=> $stable(clk_guard_q);
    endproperty
    a_clk_lock: assert property (p_clk_lock) // R13
        else $error("locked clock guard changed");

    property p_mux_lock;
        mux_guard_q[GUARD_LOCK_BIT] |=> $stable(mux_guard_q);
    endproperty
    a_mux_lock: assert property (p_mux_lock) // R13
        else $error("locked mux guard changed");

    property p_unlocked_write;
        (wr_prot_en && !mux_guard_q[GUARD_LOCK_BIT])
            |=> mux_guard_q == $past(mux_guard_wr);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) // R11
        else $error("unlocked mux guard did not take write");

    property p_reset_vals;
        $rose(aresetn) |-> short_hi_q == SHORT_HI_RST
            && short_lo_q == SHORT_LO_RST && clk_guard_q == GUARD_RST
            && stop_keep_q == STOP_KEEP_RST && mux_guard_q == GUARD_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) // R8
        else $error("wrong value after reset");

    property p_hi_upper_zero;
        (ar_take && rd_hi) |=> rvalid_q && rdata_q[31:2] == 30'h0;
    endproperty
    a_hi_upper_zero: assert property (p_hi_upper_zero) // R6
        else $error("high window register upper bits not zero");

    property p_lo_write;
        (wr_lo_en && w_strb_q == 2'h3) |=> short_lo_q == $past(w_data_q)
            ##1 short_eff_addr[21:6] == $past(w_data_q, 2);
    endproperty
    a_lo_write: assert property (p_lo_write) // R7
        else $error("low window register write lost");

    // the address flop holds its reset value one edge past reset release
    property p_eff_addr;
        $past(aresetn) |-> short_eff_addr[5:0] == $past(short_offset)
            && short_eff_addr[21:6] == $past(short_lo_q)
            && short_eff_addr[23:22] == $past(short_hi_q);
    endproperty
    a_eff_addr: assert property (p_eff_addr) // R4
        else $error("short address formed wrongly");

    property p_stop_gate;
        (stop_mode && !stop_keep_q[BIT_INTERVAL_T0])
            |=> !periph_stop_clock[BIT_INTERVAL_T0];
    endproperty
    a_stop_gate: assert property (p_stop_gate) // R1
        else $error("clock kept in stop without keep-alive");

    property p_stop_keep;
        (stop_mode && stop_keep_q[0] && periph_clock_enable_1[0])
            |=> periph_stop_clock[0];
    endproperty
    a_stop_keep: assert property (p_stop_keep) // R2
        else $error("kept clock stopped in stop mode");

    property p_write_answer;
        s_both_taken |=> bvalid_q;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write not answered in one cycle");
endmodule // sip_regs
`default_nettype wire

// ==== verilog/sip_pkg.sv ====
// Functional notes
// R1: a cleared stop keep-alive bit (interval timer 0 at bit 12, timer B 3..0 at bits 7..4, timer A 3..0 at bits 3..0) stops that clock in Stop mode.
// R2: a set stop keep-alive bit keeps the clock running in Stop mode only while the matching clock-enable bit is also set.
// R3: software writes zero to bits 11-8 of the stop keep-alive register and bits 15-4 of the protection register.
// R4: in short-address mode the address is the 18 window bits above the 6 offset bits from the instruction, a 64-word window.
// R5: the high short-address register holds address bits 23:22 in its bits 1:0.
// R6: bits 15:2 of the high short-address register read zero and ignore writes.
// R7: the low short-address register is a full 16-bit field holding address bits 21:6.
// R8: after reset the high field is all ones and the low register is all ones.
// R9: software waits five instruction cycles after changing the window before using it.
// R10: an active clock guard (bits 3:2) write-protects clock-enable, stop keep-alive and clock-rate fields.
// R11: a guard field reads 00 off, 01 on, 10 off and locked, 11 on and locked.
// R12: both guard fields reset to 00.
// R13: an unlocked guard may be rewritten freely; a locked one changes only at reset.
// R14: an active mux guard (bits 1:0) write-protects pin and internal select, pin enable, push-pull and drive registers.
// R15: the mux guard also protects the test-only pulse fields of the clock output control.
// R16: a write to a guarded field is dropped silently and still answers OKAY.
// R17: the stop keep-alive register sits at index 0xF and resets to zero.
package sip_pkg;
    localparam int          IDX_W           = 6;
    localparam logic [5:0]  IDX_STOP_KEEP_1 = 6'h0F;
    localparam logic [5:0]  IDX_SHORT_HI    = 6'h10;
    localparam logic [5:0]  IDX_SHORT_LO    = 6'h11;
    localparam logic [5:0]  IDX_WR_PROT     = 6'h12;

    localparam logic [15:0] STOP_KEEP_MASK  = 16'h10FF;
    localparam logic [15:0] STOP_KEEP_RST   = 16'h0000;
    localparam int          BIT_INTERVAL_T0 = 12;
    localparam logic [1:0]  SHORT_HI_RST    = 2'h3;
    localparam logic [15:0] SHORT_LO_RST    = 16'hFFFF;
    localparam int          OFFSET_W        = 6;

    localparam int          CLK_GUARD_LSB   = 2;
    localparam int          MUX_GUARD_LSB   = 0;
    localparam logic [1:0]  GUARD_RST       = 2'h0;
    localparam int          GUARD_ON_BIT    = 0;
    localparam int          GUARD_LOCK_BIT  = 1;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ==== verilog/sip_guard_field.sv ====
`timescale 1ns/1ps
`default_nettype none
module sip_guard_field (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_val,
    output logic      [1:0] field_q
);
    import sip_pkg::*;

    wire unlocked = ~field_q[GUARD_LOCK_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            field_q <= GUARD_RST; // R12
        end else if (wr_en && unlocked) begin // R13
            field_q <= wr_val; // R11
        end
    end
endmodule // sip_guard_field
`default_nettype wire

// ==== tb/sys_integration_protect_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module sys_integration_protect_regs_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        stop_mode;
    logic [15:0] pce1;
    logic [5:0]  short_offset;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp, cg, mg;
    wire logic [31:0] rdata;
    wire logic [15:0] stop_clk;
    wire logic [23:0] eff;
    wire logic [17:0] base;
    int          errors, tests_run;
    integer      seed;
    logic [15:0] m_keep, m_hi, m_lo, r;
    logic [1:0]  m_cg, m_mg, resp;
    logic [3:0]  codes [7];

    sip_regs #(.ADDR_W(8)) i_sip_regs (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .stop_mode(stop_mode),
        .periph_clock_enable_1(pce1), .short_offset(short_offset),
        .periph_stop_clock(stop_clk), .short_eff_addr(eff),
        .short_window_base(base), .clock_ctrl_guard(cg),
        .mux_ctrl_guard(mg)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        m_keep = 16'h0000;
        m_hi = 16'h0003;
        m_lo = 16'hFFFF;
        m_cg = 2'h0;
        m_mg = 2'h0;
    endtask

    function automatic logic [31:0] exp_val(input logic [5:0] idx);
        case (idx)
            6'h0F:   return {16'h0, m_keep};
            6'h10:   return {16'h0, m_hi};
            6'h11:   return {16'h0, m_lo};
            6'h12:   return {28'h0, m_cg, m_mg};
            default: return 32'h0;
        endcase
    endfunction

    // a write counts as mapped only inside the four-register span
    function automatic logic [1:0] exp_resp(input logic [5:0] idx);
        return (idx >= 6'h0F && idx <= 6'h12) ? 2'h0 : 2'h2;
    endfunction

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [15:0] bm;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
        check(resp, exp_resp(idx));
        bm = {{8{wstrb[1]}}, {8{wstrb[0]}}};
        case (idx)
            6'h0F: if (!m_cg[0])
                m_keep = ((m_keep & ~bm) | (d & bm)) & 16'h10FF;
            6'h10: if (wstrb[0]) m_hi = {14'h0, d[1:0]};
            6'h11: m_lo = (m_lo & ~bm) | (d & bm);
            6'h12: if (wstrb[0]) begin
                if (!m_cg[1]) m_cg = d[3:2];
                if (!m_mg[1]) m_mg = d[1:0];
            end
            default: ;
        endcase
        check(base, {m_hi[1:0], m_lo});
        check({cg, mg}, {m_cg, m_mg});
    endtask

    task automatic rd(input logic [5:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        check(rdata, exp_val(idx));
        check(rresp, exp_resp(idx));
    endtask

    initial begin
        #1_000_000;
        errors++;
        stop_test;
    end

    initial begin
        seed = 32'h679ac672;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {stop_mode, pce1, short_offset} = '0;
        do_reset;
        for (int i = 15; i <= 18; i++) rd(i[5:0]);
        for (int i = 0; i < 8; i++) begin
            // every other pair of rounds tries partial byte lanes
            wstrb <= i[1] ? 4'($random(seed)) : 4'hF;
            wr(6'h0F, 16'($random(seed)) & 16'hF0FF);
            wr(6'h10, 16'($random(seed)));
            wr(6'h11, 16'($random(seed)));
            rd(6'h0F);
            rd(6'h10);
            rd(6'h11);
            stop_mode <= 1'($random(seed));
            pce1 <= 16'($random(seed));
            short_offset <= 6'($random(seed));
            repeat (5) @(posedge aclk);
            check(stop_clk, pce1 & (~{16{stop_mode}} | m_keep));
            check(eff, {m_hi[1:0], m_lo, short_offset});
        end
        // the reset in mid-list must be the only way out of a lock
        codes = '{4'h5, 4'h0, 4'h9, 4'hE, 4'hF, 4'h0, 4'hF};
        wstrb <= 4'hF;
        for (int i = 0; i < 7; i++) begin
            if (i == 5) do_reset;
            wr(6'h12, {12'h0, codes[i]});
            r = 16'($random(seed)) & 16'hF0FF;
            wr(6'h0F, r);
            rd(6'h0F);
            rd(6'h12);
        end
        do_reset;
        rd(6'h12);
        wr(6'h13, 16'hFFFF);
        rd(6'h13);
        rd(6'h3F);
        stop_test;
    end
endmodule // sys_integration_protect_regs_test
`default_nettype wire
